// ### hdl/hpd_pkg.sv
// Shared constants of the host bus PIO/DMA port
package hpd_pkg;
  localparam int DW = 16;
  localparam int IDX_W = 8;
  localparam int IDX_WR_POS = 7;
  localparam int RW = 7;
  localparam logic [RW-1:0] REG_DMA_SETUP = 7'h21;
  localparam logic [RW-1:0] REG_XFER_CNT = 7'h22;
  localparam logic [RW-1:0] REG_DMA_STAT = 7'h23;
  localparam logic [RW-1:0] REG_DMA_CNT = 7'h24;
  localparam logic [RW-1:0] REG_SCRATCH32 = 7'h28;
  localparam logic [RW-1:0] REG_BUF = 7'h40;
  localparam int SETUP_EN = 0;
  localparam int SETUP_DIR = 1;
  localparam int SETUP_CNT_SEL = 2;
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_EXT_END = 1;
  localparam int STAT_INT_END = 2;
  localparam logic [DW-1:0] SETUP_RST = 16'h0000;
  localparam logic [DW-1:0] CNT_RST = 16'h0000;
  localparam logic [DW-1:0] ZERO_W = 16'h0000;
  localparam logic [DW-1:0] BYTES_PER_WORD = 16'h0002;
  localparam logic [7:0] CMD_UPPER = 8'h00;
  localparam int BUF_DEPTH = 16;
  localparam int HA_W = 3;
  localparam logic [HA_W-1:0] H_CMD = 3'h0;
  localparam logic [HA_W-1:0] H_WDATA = 3'h1;
  localparam logic [HA_W-1:0] H_RREQ = 3'h2;
  localparam logic [HA_W-1:0] H_RDATA = 3'h3;
  localparam logic [HA_W-1:0] H_DMA_CTL = 3'h4;
  localparam logic [HA_W-1:0] H_DMA_DATA = 3'h5;
  localparam logic [HA_W-1:0] H_DMA_LEN = 3'h6;
  localparam logic [HA_W-1:0] H_STATUS = 3'h7;
  localparam int HC_ARM = 0;
  localparam int HC_DIR = 1;
  localparam int HS_BUSY = 0;
  localparam int HS_DMA_REQUEST_OUT = 1;
  localparam int HS_ARM = 2;
  localparam logic [DW-1:0] ONE_W = 16'h0001;
endpackage

// ### hdl/hpd_bus_if.sv
// Parallel bus between processor side and device side
`timescale 1ns/1ps
interface hpd_bus_if;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic cmd_data_select;
  logic dma_acknowledge_in_low;
  logic end_of_transfer_in;
  logic dma_request_out;
  logic [hpd_pkg::DW-1:0] host_d;
  logic host_oe;
  logic [hpd_pkg::DW-1:0] dev_d;
  logic dev_oe;
  logic [hpd_pkg::DW-1:0] data;

  // Wire level of the shared data bus; undriven reads as zero
  assign data = dev_oe ? dev_d : (host_oe ? host_d : hpd_pkg::ZERO_W);

  modport dev (
    input cs_n, rd_n, wr_n, cmd_data_select, dma_acknowledge_in_low,
    input end_of_transfer_in, data,
    output dev_d, dev_oe, dma_request_out
  );
  modport host (
    output cs_n, rd_n, wr_n, cmd_data_select, dma_acknowledge_in_low,
    output end_of_transfer_in, host_d, host_oe,
    input data, dma_request_out
  );
endinterface

// ### hdl/hpd_byte_ctr.sv
// DMA byte counter with end-of-count detect
`timescale 1ns/1ps
module hpd_byte_ctr #(
  parameter int W = hpd_pkg::DW
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic clear_i,
  input wire logic step_i,
  input wire logic enable_i,
  input wire logic [W-1:0] limit_i,
  // Result
  output logic [W-1:0] count_o,
  output logic hit_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_step;

  assign cnt_step = cnt_q + W'(hpd_pkg::BYTES_PER_WORD);
  assign count_o = cnt_q;
  // Flags the word whose bytes make the count reach the limit
  assign hit_o = enable_i && step_i && (cnt_step >= limit_i);

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_q <= W'(hpd_pkg::CNT_RST);
    else if (clear_i)
      cnt_q <= W'(hpd_pkg::CNT_RST);
    else if (step_i)
      cnt_q <= cnt_step;
  end
endmodule

// ### hdl/hpd_dev_end.sv
// Device end: PIO register port, buffer and DMA channel
`timescale 1ns/1ps
// Operation
// - Select high is command, low is data
// - Sixteen-bit bus, only two port locations
// - Processor reads and writes registers and buffer
// - DMA moves words between memory and buffer
// - External DMA controller is sole bus master
// - Request out, active-low acknowledge paces DMA
// - External end-of-transfer input stops DMA
// - Counter reaching byte count ends DMA
// - Setup register holds the counter enable
// - Working clock comes from on-chip PLL
// - Names ending _n are asserted low
// - Command word: index low byte, zero upper
// - Command then data phases, low half first
// - Strobes give direction of each access
// - DMA cycles repeat until end-of-transfer
module hpd_dev_end #(
  parameter int BUF_DEPTH = hpd_pkg::BUF_DEPTH
) (
  // Clock and reset; mclk_i stands for the PLL output
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Processor bus
  hpd_bus_if.dev bus_if,
  // User side
  output logic dma_active_o,
  output logic xfer_end_o,
  output logic [hpd_pkg::DW-1:0] setup_o
);
  localparam int AW = $clog2(BUF_DEPTH);

  logic [hpd_pkg::IDX_W-1:0] idx_q;
  logic [hpd_pkg::DW-1:0] setup_q;
  logic [hpd_pkg::DW-1:0] xcnt_q;
  logic [2*hpd_pkg::DW-1:0] scr_q;
  logic [hpd_pkg::DW-1:0] buf_q [BUF_DEPTH];
  logic [AW-1:0] ptr_q;
  logic hi_q;
  logic active_q;
  logic ext_end_q;
  logic int_end_q;
  logic end_q;
  logic [hpd_pkg::DW-1:0] rdata_q;
  logic oe_q;
  logic [hpd_pkg::DW-1:0] rdata_d;
  logic [hpd_pkg::DW-1:0] dcnt;
  logic hit;

  logic sel;
  logic no_ack;
  logic pio_wr;
  logic cmd_wr;
  logic data_wr;
  logic data_rd;
  logic dma_wr;
  logic dma_rd;
  logic dma_step;
  logic ext_term;
  logic term;
  logic idx_wr;
  logic [hpd_pkg::RW-1:0] idx_reg;
  logic start;
  logic buf_wr;
  logic buf_rd;
  logic scr_acc;

  assign sel = !bus_if.cs_n;
  assign no_ack = bus_if.dma_acknowledge_in_low;
  assign pio_wr = sel && !bus_if.wr_n && no_ack;
  assign cmd_wr = pio_wr && bus_if.cmd_data_select;
  assign data_wr = pio_wr && !bus_if.cmd_data_select;
  // Command port is write only, so reads with select high are ignored
  assign data_rd = sel && !bus_if.rd_n && !bus_if.cmd_data_select
    && no_ack;
  // Acks outside an active transfer are dropped
  assign dma_wr = active_q && !no_ack && !bus_if.wr_n
    && setup_q[hpd_pkg::SETUP_DIR];
  assign dma_rd = active_q && !no_ack && !bus_if.rd_n
    && !setup_q[hpd_pkg::SETUP_DIR];
  assign dma_step = dma_wr || dma_rd;
  assign ext_term = active_q && bus_if.end_of_transfer_in;
  assign term = ext_term || hit;

  assign idx_wr = idx_q[hpd_pkg::IDX_WR_POS];
  assign idx_reg = idx_q[hpd_pkg::RW-1:0];
  assign start = data_wr && idx_wr && (idx_reg == hpd_pkg::REG_DMA_SETUP)
    && bus_if.data[hpd_pkg::SETUP_EN];
  assign buf_wr = (data_wr && idx_wr && (idx_reg == hpd_pkg::REG_BUF))
    || dma_wr;
  assign buf_rd = (data_rd && !idx_wr && (idx_reg == hpd_pkg::REG_BUF))
    || dma_rd;
  assign scr_acc = (data_wr && idx_wr || data_rd && !idx_wr)
    && (idx_reg == hpd_pkg::REG_SCRATCH32);

  hpd_byte_ctr #(
    .W(hpd_pkg::DW)
  ) i_hpd_byte_ctr (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .clear_i(start),
    .step_i(dma_step),
    .enable_i(setup_q[hpd_pkg::SETUP_CNT_SEL]),
    .limit_i(xcnt_q),
    .count_o(dcnt),
    .hit_o(hit)
  );

  // Upper command byte is not decoded; software keeps it zero
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      idx_q <= '0;
    else if (cmd_wr)
      idx_q <= bus_if.data[hpd_pkg::IDX_W-1:0];
  end

  // Control registers
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      setup_q <= hpd_pkg::SETUP_RST;
      xcnt_q <= hpd_pkg::CNT_RST;
    end
    else if (data_wr && idx_wr)
    begin
      case (idx_reg)
        hpd_pkg::REG_DMA_SETUP: setup_q <= bus_if.data;
        hpd_pkg::REG_XFER_CNT: xcnt_q <= bus_if.data;
        default: ;
      endcase
    end
  end

  // 32-bit register: low half first, then high half
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      scr_q <= '0;
      hi_q <= 1'b0;
    end
    else if (cmd_wr)
      hi_q <= 1'b0;
    else if (scr_acc)
    begin
      hi_q <= !hi_q;
      if (data_wr && !hi_q)
        scr_q[hpd_pkg::DW-1:0] <= bus_if.data;
      else if (data_wr)
        scr_q[2*hpd_pkg::DW-1:hpd_pkg::DW] <= bus_if.data;
    end
  end

  // Buffer pointer; restarts on a new command or transfer
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ptr_q <= '0;
    else if (cmd_wr || start)
      ptr_q <= '0;
    else if (buf_wr || buf_rd)
      ptr_q <= ptr_q + 1'b1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (buf_wr)
      buf_q[ptr_q] <= bus_if.data;
  end

  // Transfer state; a fresh setup wins over a pending end
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      active_q <= 1'b0;
      ext_end_q <= 1'b0;
      int_end_q <= 1'b0;
      end_q <= 1'b0;
    end
    else
    begin
      end_q <= term && !start;
      if (start)
      begin
        active_q <= 1'b1;
        ext_end_q <= 1'b0;
        int_end_q <= 1'b0;
      end
      else if (term)
      begin
        active_q <= 1'b0;
        ext_end_q <= ext_term;
        int_end_q <= hit && !ext_term;
      end
    end
  end

  function automatic logic [hpd_pkg::DW-1:0] half(
    input logic [2*hpd_pkg::DW-1:0] v,
    input logic upper
  );
    half = upper ? v[2*hpd_pkg::DW-1:hpd_pkg::DW] : v[hpd_pkg::DW-1:0];
  endfunction

  // Read mux; write indices and unmapped indices read as zero
  always_comb
  begin
    rdata_d = hpd_pkg::ZERO_W;
    if (dma_rd)
      rdata_d = buf_q[ptr_q];
    else if (!idx_wr)
    begin
      case (idx_reg)
        hpd_pkg::REG_DMA_SETUP: rdata_d = setup_q;
        hpd_pkg::REG_XFER_CNT: rdata_d = xcnt_q;
        hpd_pkg::REG_DMA_STAT:
        begin
          rdata_d[hpd_pkg::STAT_ACTIVE] = active_q;
          rdata_d[hpd_pkg::STAT_EXT_END] = ext_end_q;
          rdata_d[hpd_pkg::STAT_INT_END] = int_end_q;
        end
        hpd_pkg::REG_DMA_CNT: rdata_d = dcnt;
        hpd_pkg::REG_SCRATCH32: rdata_d = half(scr_q, hi_q);
        hpd_pkg::REG_BUF: rdata_d = buf_q[ptr_q];
        default: rdata_d = hpd_pkg::ZERO_W;
      endcase
    end
  end

  // Read word is driven in the cycle after the strobe, one cycle only
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_q <= hpd_pkg::ZERO_W;
      oe_q <= 1'b0;
    end
    else
    begin
      oe_q <= data_rd || dma_rd;
      rdata_q <= rdata_d;
    end
  end

  assign bus_if.dev_d = rdata_q;
  assign bus_if.dev_oe = oe_q;
  assign bus_if.dma_request_out = active_q;
  assign dma_active_o = active_q;
  assign xfer_end_o = end_q;
  assign setup_o = setup_q;
endmodule

// ### hdl/hpd_host_end.sv
// Processor end: bus master for PIO cycles and DMA cycles
`timescale 1ns/1ps
module hpd_host_end (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Command port
  input wire logic [hpd_pkg::HA_W-1:0] addr_i,
  input wire logic [hpd_pkg::DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [hpd_pkg::DW-1:0] rdata_o,
  // Processor bus
  hpd_bus_if.host bus_if
);
  typedef enum {HS_IDLE, HS_CMD, HS_WR, HS_RD, HS_RCAP, HS_DACK, HS_DGAP}
    hpd_hst_t;

  hpd_hst_t st_q;
  logic cs_n_q;
  logic rd_n_q;
  logic wr_n_q;
  logic a0_q;
  logic dma_acknowledge_in_low_q;
  logic eot_q;
  logic oe_q;
  logic [hpd_pkg::DW-1:0] d_q;
  logic [hpd_pkg::DW-1:0] last_q;
  logic [hpd_pkg::DW-1:0] ctl_q;
  logic [hpd_pkg::DW-1:0] ddata_q;
  logic [hpd_pkg::DW-1:0] len_q;
  logic [hpd_pkg::DW-1:0] words_q;
  logic [hpd_pkg::DW-1:0] rdata_q;
  logic [hpd_pkg::DW-1:0] stat;
  logic idle;
  logic go_cmd;
  logic go_wr;
  logic go_rd;
  logic go_dma;
  logic last_word;
  logic dir_wr;

  assign idle = (st_q == HS_IDLE);
  // Requests while busy are dropped
  assign go_cmd = idle && wr_i && (addr_i == hpd_pkg::H_CMD);
  assign go_wr = idle && wr_i && (addr_i == hpd_pkg::H_WDATA);
  assign go_rd = idle && wr_i && (addr_i == hpd_pkg::H_RREQ);
  // Only this end starts cycles; the device only requests
  assign go_dma = idle && !wr_i && ctl_q[hpd_pkg::HC_ARM]
    && bus_if.dma_request_out;
  assign dir_wr = ctl_q[hpd_pkg::HC_DIR];
  assign last_word = (len_q != hpd_pkg::ZERO_W)
    && (words_q + hpd_pkg::ONE_W == len_q);

  // Pin sequencer: every strobe is low for exactly one cycle
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= HS_IDLE;
      cs_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      a0_q <= 1'b0;
      dma_acknowledge_in_low_q <= 1'b1;
      eot_q <= 1'b0;
      oe_q <= 1'b0;
      d_q <= hpd_pkg::ZERO_W;
    end
    else
    begin
      cs_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      dma_acknowledge_in_low_q <= 1'b1;
      eot_q <= 1'b0;
      oe_q <= 1'b0;
      case (st_q)
        HS_IDLE:
        begin
          if (go_cmd)
          begin
            st_q <= HS_CMD;
            cs_n_q <= 1'b0;
            wr_n_q <= 1'b0;
            a0_q <= 1'b1;
            oe_q <= 1'b1;
            d_q <= {hpd_pkg::CMD_UPPER, wdata_i[7:0]};
          end
          else if (go_wr || go_rd)
          begin
            st_q <= go_wr ? HS_WR : HS_RD;
            cs_n_q <= 1'b0;
            wr_n_q <= !go_wr;
            rd_n_q <= !go_rd;
            a0_q <= 1'b0;
            oe_q <= go_wr;
            d_q <= wdata_i;
          end
          else if (go_dma)
          begin
            st_q <= HS_DACK;
            dma_acknowledge_in_low_q <= 1'b0;
            wr_n_q <= !dir_wr;
            rd_n_q <= dir_wr;
            oe_q <= dir_wr;
            d_q <= ddata_q;
            eot_q <= last_word;
          end
        end
        HS_CMD: st_q <= HS_IDLE;
        HS_WR: st_q <= HS_IDLE;
        HS_RD: st_q <= HS_RCAP;
        HS_RCAP: st_q <= HS_IDLE;
        // Gap lets the device drop its request before the next ack
        HS_DACK: st_q <= HS_DGAP;
        HS_DGAP: st_q <= HS_IDLE;
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  // Word captured from the device
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      last_q <= hpd_pkg::ZERO_W;
    else if (st_q == HS_RCAP || (st_q == HS_DGAP && !dir_wr))
      last_q <= bus_if.data;
  end

  // DMA settings; software write wins over auto-disarm
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctl_q <= hpd_pkg::ZERO_W;
      ddata_q <= hpd_pkg::ZERO_W;
      len_q <= hpd_pkg::ZERO_W;
      words_q <= hpd_pkg::ZERO_W;
    end
    else
    begin
      if (wr_i && addr_i == hpd_pkg::H_DMA_CTL)
      begin
        ctl_q <= wdata_i;
        words_q <= hpd_pkg::ZERO_W;
      end
      else if (go_dma)
      begin
        words_q <= words_q + hpd_pkg::ONE_W;
        if (last_word)
          ctl_q[hpd_pkg::HC_ARM] <= 1'b0;
      end
      if (wr_i && addr_i == hpd_pkg::H_DMA_DATA)
        ddata_q <= wdata_i;
      else if (go_dma && dir_wr)
        ddata_q <= ddata_q + hpd_pkg::ONE_W;
      if (wr_i && addr_i == hpd_pkg::H_DMA_LEN)
        len_q <= wdata_i;
    end
  end

  always_comb
  begin
    stat = words_q;
    stat[hpd_pkg::HS_BUSY] = !idle;
    stat[hpd_pkg::HS_DMA_REQUEST_OUT] = bus_if.dma_request_out;
    stat[hpd_pkg::HS_ARM] = ctl_q[hpd_pkg::HC_ARM];
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_q <= hpd_pkg::ZERO_W;
    else if (rd_i)
    begin
      case (addr_i)
        hpd_pkg::H_RDATA: rdata_q <= last_q;
        hpd_pkg::H_DMA_CTL: rdata_q <= ctl_q;
        hpd_pkg::H_DMA_DATA: rdata_q <= ddata_q;
        hpd_pkg::H_DMA_LEN: rdata_q <= len_q;
        hpd_pkg::H_STATUS: rdata_q <= {words_q[12:0], stat[2:0]};
        default: rdata_q <= hpd_pkg::ZERO_W;
      endcase
    end
  end

  assign rdata_o = rdata_q;
  assign bus_if.cs_n = cs_n_q;
  assign bus_if.rd_n = rd_n_q;
  assign bus_if.wr_n = wr_n_q;
  assign bus_if.cmd_data_select = a0_q;
  assign bus_if.dma_acknowledge_in_low = dma_acknowledge_in_low_q;
  assign bus_if.end_of_transfer_in = eot_q;
  assign bus_if.host_d = d_q;
  assign bus_if.host_oe = oe_q;
endmodule

// ### verif/hpd_bus_props.sv
// Concurrent checks on the processor bus between both ends
`timescale 1ns/1ps
module hpd_bus_props (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Bus signals
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic cmd_data_select,
  input wire logic dma_acknowledge_in_low,
  input wire logic end_of_transfer_in,
  input wire logic dma_request_out,
  input wire logic host_oe,
  input wire logic dev_oe,
  input wire logic [hpd_pkg::DW-1:0] data
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_pio_read;
    !cs_n && !rd_n && !cmd_data_select && dma_acknowledge_in_low |=> dev_oe;
  endproperty
  a_pio_read: assert property (p_pio_read) else $error("no read data");
  property p_oe_cause;
    dev_oe |-> $past(rd_n) == 1'b0;
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("stray drive");
  property p_dma_read;
    !dma_acknowledge_in_low && !rd_n && dma_request_out |=> dev_oe ##1 !dev_oe;
  endproperty
  a_dma_read: assert property (p_dma_read) else $error("dma read word");
  property p_one_dir;
    !(!rd_n && !wr_n);
  endproperty
  a_one_dir: assert property (p_one_dir) else $error("both strobes");
  property p_one_driver;
    !(dev_oe && host_oe);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("bus clash");
  property p_ack_req;
    !dma_acknowledge_in_low |-> dma_request_out;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack unasked");
  property p_eot_stop;
    end_of_transfer_in && dma_request_out |=> !dma_request_out [*2];
  endproperty
  a_eot_stop: assert property (p_eot_stop) else $error("eot late");
  property p_start;
    $rose(dma_request_out) |-> $past(wr_n) == 1'b0 && !$past(cmd_data_select);
  endproperty
  a_start: assert property (p_start) else $error("request unprompted");
  property p_cmd_word;
    !cs_n && !wr_n && cmd_data_select |-> data[15:8] == 8'h00;
  endproperty
  a_cmd_word: assert property (p_cmd_word) else $error("cmd upper");
  property p_wr_pulse;
    !wr_n |=> wr_n;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("long strobe");

  c_pio_read: cover property (!cs_n && !rd_n && !cmd_data_select);
  c_eot: cover property (end_of_transfer_in && dma_request_out);
  c_dma_request_out_fall: cover property ($fell(dma_request_out));
endmodule

// ### verif/host_bus_pio_dma_port_test.sv
// Self-checking bench: host end and device end joined by the bus
`timescale 1ns/1ps
module host_bus_pio_dma_port_test;
  localparam int LIMIT = 20000;
  logic mclk_i;
  logic rst_n_i;
  logic [hpd_pkg::HA_W-1:0] addr_i;
  logic [15:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [15:0] rdata_o;
  logic dma_active_o;
  logic xfer_end_o;
  logic [15:0] setup_o;
  logic [17:0] snap;
  logic [15:0] v;
  int bad_count;
  int cmp_count;
  int cyc;
  int end_cnt;
  int e;

  hpd_bus_if i_hpd_bus_if();
  hpd_dev_end i_hpd_dev_end (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .bus_if(i_hpd_bus_if), .dma_active_o(dma_active_o),
    .xfer_end_o(xfer_end_o), .setup_o(setup_o));
  hpd_host_end i_hpd_host_end (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .bus_if(i_hpd_bus_if));
  hpd_bus_props i_hpd_bus_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .cs_n(i_hpd_bus_if.cs_n), .rd_n(i_hpd_bus_if.rd_n),
    .wr_n(i_hpd_bus_if.wr_n),
    .cmd_data_select(i_hpd_bus_if.cmd_data_select),
    .dma_acknowledge_in_low(i_hpd_bus_if.dma_acknowledge_in_low),
    .end_of_transfer_in(i_hpd_bus_if.end_of_transfer_in),
    .dma_request_out(i_hpd_bus_if.dma_request_out),
    .host_oe(i_hpd_bus_if.host_oe), .dev_oe(i_hpd_bus_if.dev_oe),
    .data(i_hpd_bus_if.data));

  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  // Hang guard and count of end-of-transfer pulses
  always @(posedge mclk_i)
  begin
    cyc = cyc + 1;
    if (xfer_end_o === 1'b1)
      end_cnt = end_cnt + 1;
    if (cyc == LIMIT)
    begin
      bad_count++;
      results();
    end
  end

  task results;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  // Snapshot of the wire taken in the cycle the host strobes it
  task hw(input logic [2:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(negedge mclk_i);
    snap = {i_hpd_bus_if.cs_n, i_hpd_bus_if.cmd_data_select,
      i_hpd_bus_if.data};
    @(posedge mclk_i);
  endtask

  task hr(input logic [2:0] a, output logic [15:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    d = rdata_o;
    @(posedge mclk_i);
  endtask

  // Writes to the PIO offsets are dropped while busy
  task idle;
    logic [15:0] s;
    int n;
    s = 16'h0001;
    n = 0;
    while (s[0] !== 1'b0 && n < 50)
    begin
      hr(hpd_pkg::H_STATUS, s);
      n++;
    end
    chk("host busy", 16'h0000, {15'h0000, s[0]});
  endtask

  task cmd(input logic [7:0] idx);
    hw(hpd_pkg::H_CMD, {8'h00, idx});
    idle();
  endtask

  task dwr(input logic [15:0] d);
    hw(hpd_pkg::H_WDATA, d);
    idle();
  endtask

  task drd(output logic [15:0] d);
    hw(hpd_pkg::H_RREQ, 16'h0000);
    idle();
    hr(hpd_pkg::H_RDATA, d);
  endtask

  task rd_reg(input logic [7:0] idx, output logic [15:0] d);
    cmd(idx);
    drd(d);
  endtask

  // Sampled off the edge so the flop update has landed
  task wait_end;
    int n;
    n = 0;
    @(negedge mclk_i);
    while (dma_active_o !== 1'b0 && n < 300)
    begin
      @(negedge mclk_i);
      n++;
    end
    chk("dma end", 16'h0000, {15'h0000, dma_active_o});
    @(posedge mclk_i);
    idle();
  endtask

  task t_regs;
    cmd(8'h21);
    chk("cmd word", 16'h0021, snap[15:0]);
    chk("cmd select", 16'h0001, {14'h0000, snap[17:16]});
    drd(v);
    chk("setup reset", hpd_pkg::SETUP_RST, v);
    rd_reg(8'h22, v);
    chk("count reset", hpd_pkg::CNT_RST, v);
    cmd(8'ha2);
    dwr(16'h1234);
    rd_reg(8'h22, v);
    chk("byte count", 16'h1234, v);
    cmd(8'h22);
    dwr(16'h5555);
    rd_reg(8'h22, v);
    chk("read index write", 16'h1234, v);
    rd_reg(8'ha2, v);
    chk("write index read", 16'h0000, v);
    rd_reg(8'h7f, v);
    chk("unmapped", 16'h0000, v);
    cmd(8'ha1);
    dwr(16'h0004);
    chk("setup_o", 16'h0004, setup_o);
    rd_reg(8'h21, v);
    chk("setup", 16'h0004, v);
    $display("test regs done");
  endtask

  task t_wide;
    cmd(8'ha8);
    dwr(16'h1111);
    dwr(16'h2222);
    rd_reg(8'h28, v);
    chk("low half", 16'h1111, v);
    drd(v);
    chk("high half", 16'h2222, v);
    $display("test wide done");
  endtask

  task t_buf;
    cmd(8'hc0);
    for (int i = 0; i < 3; i++)
      dwr(16'h0c00 + 16'(i));
    cmd(8'h40);
    for (int i = 0; i < 3; i++)
    begin
      drd(v);
      chk("pio buffer", 16'h0c00 + 16'(i), v);
    end
    $display("test buffer done");
  endtask

  task t_dma_cnt;
    e = end_cnt;
    cmd(8'ha2);
    dwr(16'h0006);
    cmd(8'ha1);
    dwr(16'h0007);
    chk("active", 16'h0001, {15'h0000, dma_active_o});
    hw(hpd_pkg::H_DMA_LEN, 16'h0000);
    hw(hpd_pkg::H_DMA_DATA, 16'hab00);
    hw(hpd_pkg::H_DMA_CTL, 16'h0003);
    wait_end();
    chk("end pulses", 16'(e + 1), 16'(end_cnt));
    hr(hpd_pkg::H_STATUS, v);
    chk("host words", 16'h0003, {3'h0, v[15:3]});
    // Still armed, request low, not busy
    chk("host status", 16'h001c, v);
    hr(hpd_pkg::H_DMA_DATA, v);
    chk("next dma word", 16'hab03, v);
    // Disarm, or the next setup would be acked in the old direction
    hw(hpd_pkg::H_DMA_CTL, 16'h0000);
    hr(hpd_pkg::H_DMA_CTL, v);
    chk("disarm", 16'h0000, v);
    rd_reg(8'h23, v);
    chk("count end", 16'h0004, v & 16'h0007);
    rd_reg(8'h24, v);
    chk("dma bytes", 16'h0006, v);
    cmd(8'h40);
    for (int i = 0; i < 3; i++)
    begin
      drd(v);
      chk("dma buffer", 16'hab00 + 16'(i), v);
    end
    $display("test dma count done");
  endtask

  task t_dma_ext;
    e = end_cnt;
    cmd(8'ha1);
    dwr(16'h0001);
    hw(hpd_pkg::H_DMA_LEN, 16'h0002);
    hr(hpd_pkg::H_DMA_LEN, v);
    chk("host len", 16'h0002, v);
    hw(hpd_pkg::H_DMA_CTL, 16'h0001);
    wait_end();
    hr(hpd_pkg::H_RDATA, v);
    chk("dma read", 16'hab01, v);
    chk("end pulses", 16'(e + 1), 16'(end_cnt));
    rd_reg(8'h23, v);
    chk("ext end", 16'h0002, v & 16'h0007);
    rd_reg(8'h24, v);
    chk("dma bytes", 16'h0004, v);
    $display("test dma eot done");
  endtask

  initial
  begin
    rst_n_i = 1'b0;
    addr_i = '0;
    wdata_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    end_cnt = 0;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    t_regs();
    t_wide();
    t_buf();
    t_dma_cnt();
    t_dma_ext();
    results();
  end
endmodule
